// ### hw/fpg_defs.svh
/*
 * Constants of the flash program/erase guard: key codes, page geometry,
 * reserved area and operation times with their cycle counts.
 * Assumes a 200 MHz system clock; included by bare name.
 */
// Contract
// R1: Flash is programmed one byte per operation, from debug port or store.
// R2: A byte write only clears bits; only erase returns bytes to 0xFF.
// R3: Writes and erases are timed inside; no completion polling is needed.
// R4: The processor is stalled while a write or erase runs.
// R5: Key register must get 0xA5 then 0xF1 before each software operation.
// R6: Any gap between the two key writes is fine; order and values matter.
// R7: A wrong or out-of-order key blocks software modification until reset.
// R8: A software write or erase before a full key pair also blocks until reset.
// R9: After each finished write or erase the key checker locks again; the code relocks it after software operations only, not debug ones.
// R10: With store write enable set, stores go to flash, not data RAM.
// R11: Store write enable holds across operations; clears by software or reset.
// R12: Modify needs write enable; page erase needs write and erase enable.
// R13: Both enables plus key: a store erases the whole 512-byte page.
// R14: Write enable only plus key: a store programs exactly the addressed byte.
// R15: Requester rewrites both keys and a new store for every byte.
// R16: Software should clear write enable afterwards and mask interrupts.
// R17: Loads always reach data RAM; flash is read by code-read only.
// R18: In the 8 KiB part, 0x1E00 to 0x1FFF is reserved, outside user flash.
// R19: Lock byte at the last user byte locks its ones' complement of pages.
// R20: Page holding lock byte is locked unless the lock byte is all ones.
// R21: Flash is 512-byte pages; an erase clears exactly one aligned page.
// R22: Prohibited software access from an unlocked page raises flash-error reset.
// R23: Prohibited debug-port operations are silently ignored, no reset.
// R24: A written lock byte takes effect only after the next device reset.
// R25: Reset clears both enables and relocks the key checker, removing lockout.
`ifndef FPG_DEFS_SVH
`define FPG_DEFS_SVH

`define FPG_KEY_FIRST       8'hA5
`define FPG_KEY_SECOND      8'hF1
`define FPG_ERASED_BYTE     8'hFF
`define FPG_PAGE_BYTES      512
`define FPG_PAGE_SHIFT      9
`define FPG_FLASH_BYTES     8192
`define FPG_ADDR_W          13
`define FPG_RESERVED_BASE   13'h1E00
`define FPG_CLK_MHZ         200
`define FPG_WRITE_TIME_US   40
`define FPG_ERASE_TIME_MS   10
`define FPG_WRITE_CYCLES    (`FPG_WRITE_TIME_US * `FPG_CLK_MHZ)
`define FPG_ERASE_CYCLES    (`FPG_ERASE_TIME_MS * 1000 * `FPG_CLK_MHZ)

`endif

// ### hw/fpg_flash_engine.sv
/*
 * Flash array with internally timed byte program and page erase.
 * Assumes one start pulse at a time, given only while busy is low.
 */
`timescale 1ns/100ps
`include "fpg_defs.svh"
module fpg_flash_engine
    import fpg_pkg::*;
#(
    parameter int DEPTH        = `FPG_FLASH_BYTES,
    parameter int WRITE_CYCLES = `FPG_WRITE_CYCLES,
    parameter int ERASE_CYCLES = `FPG_ERASE_CYCLES
)
(
    input  wire logic i_clk,
    input  wire logic i_reset_n,
    fpg_flash_if.eng  fl
);
    localparam int CW = $clog2(ERASE_CYCLES + 1);
    localparam int PW = `FPG_PAGE_SHIFT;

    // Blank part reads erased
    logic [7:0]    mem_reg [DEPTH] = '{default: `FPG_ERASED_BYTE};
    fpg_eng_e      state_reg;
    logic [CW-1:0] count_reg;
    logic [PW-1:0] sweep_reg;

    // =========================================================
    // Operation timing
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            state_reg <= FPG_ENG_IDLE;
            count_reg <= '0;
            sweep_reg <= '0;
            fl.done   <= 1'b0;
        end
        else
        begin
            fl.done <= 1'b0;
            unique case (state_reg)
                FPG_ENG_IDLE:
                    if (fl.start)
                    begin
                        state_reg <= FPG_ENG_WAIT;
                        count_reg <= fl.erase ? CW'(ERASE_CYCLES - 1)
                                              : CW'(WRITE_CYCLES - 1);  // [R3]
                    end
                FPG_ENG_WAIT:
                    if (count_reg != '0)
                        count_reg <= count_reg - CW'(1);
                    else if (fl.erase)
                    begin
                        state_reg <= FPG_ENG_SWEEP;
                        sweep_reg <= '0;
                    end
                    else
                    begin
                        state_reg <= FPG_ENG_IDLE;
                        fl.done   <= 1'b1;
                    end
                FPG_ENG_SWEEP:
                begin
                    sweep_reg <= sweep_reg + PW'(1);
                    if (sweep_reg == '1)
                    begin
                        state_reg <= FPG_ENG_IDLE;
                        fl.done   <= 1'b1;
                    end
                end
                default:
                    state_reg <= FPG_ENG_IDLE;
            endcase
        end
    end

    assign fl.busy = (state_reg != FPG_ENG_IDLE);

    // =========================================================
    // Array update and read
    always_ff @(posedge i_clk)
    begin
        if (state_reg == FPG_ENG_WAIT && count_reg == '0 && !fl.erase)
            mem_reg[fl.addr] <= mem_reg[fl.addr] & fl.wdata;                 // [R2] [R14]
        else if (state_reg == FPG_ENG_SWEEP)
            mem_reg[{fl.addr[$bits(fl.addr)-1:PW], sweep_reg}] <= `FPG_ERASED_BYTE;  // [R21]
        fl.rd_data <= mem_reg[fl.rd_addr];
    end

endmodule

// ### hw/fpg_flash_if.sv
/*
 * Link between the guard controller and its flash array engine.
 * Assumes both ends share the system clock.
 */
`timescale 1ns/100ps
interface fpg_flash_if #(parameter int AW = 13);
    logic          start;
    logic          erase;
    logic [AW-1:0] addr;
    logic [7:0]    wdata;
    logic          busy;
    logic          done;
    logic [AW-1:0] rd_addr;
    logic [7:0]    rd_data;

    modport ctrl (output start, erase, addr, wdata, rd_addr, input busy, done, rd_data);
    modport eng  (input start, erase, addr, wdata, rd_addr, output busy, done, rd_data);
endinterface

// ### hw/fpg_guard.sv
/*
 * Flash program/erase guard: key lock, store routing, lock-byte page
 * protection and processor stall around timed flash operations.
 * Assumes store, load, code-read, key and debug requests are issued by
 * logic on i_clk, one per cycle, and none by the core while stalled.
 */
`timescale 1ns/100ps
`include "fpg_defs.svh"
module fpg_guard
    import fpg_pkg::*;
#(
    parameter int DEPTH        = `FPG_FLASH_BYTES,
    parameter int WRITE_CYCLES = `FPG_WRITE_CYCLES,
    parameter int ERASE_CYCLES = `FPG_ERASE_CYCLES
)
(
    input  wire logic        i_clk,
    input  wire logic        i_reset_n,
    input  wire logic        i_ctrl_wr,
    input  wire logic        i_ctrl_write_en,
    input  wire logic        i_ctrl_erase_en,
    input  wire logic        i_key_wr,
    input  wire logic [7:0]  i_key_data,
    input  wire logic        i_store_valid,
    input  wire logic [12:0] i_store_addr,
    input  wire logic [7:0]  i_store_data,
    input  wire logic        i_load_valid,
    input  wire logic [12:0] i_load_addr,
    input  wire logic        i_code_rd,
    input  wire logic [12:0] i_code_addr,
    input  wire logic [12:0] i_exec_addr,
    input  wire logic        i_dbg_req,
    input  wire logic        i_dbg_erase,
    input  wire logic [12:0] i_dbg_addr,
    input  wire logic [7:0]  i_dbg_data,
    output logic             o_stall,
    output logic             o_store_write_enable,
    output logic             o_store_erase_enable,
    output logic [1:0]       o_key_state,
    output logic             o_xram_wr,
    output logic             o_xram_rd,
    output logic [12:0]      o_xram_addr,
    output logic [7:0]       o_xram_data,
    output logic             o_code_valid,
    output logic [7:0]       o_code_data,
    output logic             o_dbg_ack,
    output logic             o_dbg_ignored,
    output logic             o_flash_error_reset,
    output logic [7:0]       o_lock_byte
);
    localparam int          AW        = `FPG_ADDR_W;
    localparam int          PS        = `FPG_PAGE_SHIFT;
    localparam bit          HAS_RSV   = (DEPTH == `FPG_FLASH_BYTES);
    localparam logic [AW:0] USER_END  = HAS_RSV ? {1'b0, `FPG_RESERVED_BASE}
                                                : (AW+1)'(DEPTH);
    localparam logic [AW-1:0] LOCK_ADDR = AW'(USER_END - (AW+1)'(1));

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    fpg_flash_if #(.AW(AW)) fl ();

    fpg_key_e       key_reg;
    logic           wen_reg;
    logic           een_reg;
    logic [7:0]     lock_reg;
    logic [1:0]     init_reg;
    logic           stall_reg;
    logic           op_dbg_reg;
    logic           code_pend_reg;
    logic           code_err_reg;
    logic           start_reg;
    logic           erase_reg;
    logic [AW-1:0]  addr_reg;
    logic [7:0]     wdata_reg;

    // =========================================================
    // Protection decode
    function automatic logic in_reserved(input logic [AW-1:0] a);
        in_reserved = HAS_RSV && (a >= `FPG_RESERVED_BASE);                  // [R18]
    endfunction

    function automatic logic page_locked(input logic [AW-1:0] a, input logic [7:0] lb);
        logic [7:0] n;
        n = ~lb;                                                             // [R19]
        page_locked = ({4'b0000, a[AW-1:PS]} < n)
                   || ((a[AW-1:PS] == LOCK_ADDR[AW-1:PS]) && (lb != `FPG_ERASED_BYTE));  // [R20]
    endfunction

    // Software may never erase the lock page nor change a set lock byte
    function automatic logic sw_denied(input logic [AW-1:0] a, input logic er,
                                       input logic from_locked, input logic [7:0] lb);
        sw_denied = in_reserved(a)
                 || (er && a[AW-1:PS] == LOCK_ADDR[AW-1:PS])
                 || (!er && a == LOCK_ADDR && lb != `FPG_ERASED_BYTE)
                 || (!from_locked && page_locked(a, lb));
    endfunction

    logic init_done;
    logic exec_locked;
    logic sw_flash;
    logic sw_err;
    logic sw_go;
    logic code_err;
    logic dbg_block;
    logic dbg_go;

    assign init_done   = (init_reg == 2'd2);
    assign exec_locked = page_locked(i_exec_addr, lock_reg);
    assign sw_flash    = i_store_valid && wen_reg && !stall_reg;             // [R10]
    assign sw_err      = sw_flash && sw_denied(i_store_addr, een_reg, exec_locked, lock_reg);
    assign sw_go       = sw_flash && !sw_err && (key_reg == FPG_KEY_OPEN);   // [R5] [R12]
    assign code_err    = i_code_rd && !stall_reg
                      && (in_reserved(i_code_addr)
                          || (!exec_locked && page_locked(i_code_addr, lock_reg)));
    assign dbg_block   = in_reserved(i_dbg_addr) || page_locked(i_dbg_addr, lock_reg)
                      || (!i_dbg_erase && i_dbg_addr == LOCK_ADDR
                          && lock_reg != `FPG_ERASED_BYTE);
    assign dbg_go      = i_dbg_req && !stall_reg && !i_store_valid && !dbg_block;

    // =========================================================
    // Lock byte capture after reset
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            init_reg <= 2'd0;
            lock_reg <= `FPG_ERASED_BYTE;
        end
        else if (init_reg == 2'd0)
            init_reg <= 2'd1;
        else if (init_reg == 2'd1)
        begin
            init_reg <= 2'd2;
            lock_reg <= fl.rd_data;                                          // [R24]
        end
    end

    assign fl.rd_addr = init_done ? i_code_addr : LOCK_ADDR;

    a_lock_frozen: assert property (init_done |=> $stable(lock_reg))         // [R24]
        else $error("lock byte changed after capture");

    // =========================================================
    // Store enables
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            wen_reg <= 1'b0;                                                 // [R25]
            een_reg <= 1'b0;
        end
        else if (i_ctrl_wr)
        begin
            wen_reg <= i_ctrl_write_en;                                      // [R11]
            een_reg <= i_ctrl_erase_en;
        end
    end

    a_wen_holds: assert property (wen_reg && !i_ctrl_wr |=> wen_reg)         // [R11]
        else $error("write enable dropped without a control write");

    // =========================================================
    // Key checker
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            key_reg <= FPG_KEY_LOCKED;                                       // [R25]
        else if (fl.done && !op_dbg_reg)
        begin
            if (key_reg != FPG_KEY_LOCKOUT)
                key_reg <= FPG_KEY_LOCKED;                                   // [R9]
        end
        else if (i_key_wr)
        begin
            unique case (key_reg)
                FPG_KEY_LOCKED:
                    key_reg <= (i_key_data == `FPG_KEY_FIRST) ? FPG_KEY_HALF
                                                              : FPG_KEY_LOCKOUT;   // [R5] [R7]
                FPG_KEY_HALF:
                    key_reg <= (i_key_data == `FPG_KEY_SECOND) ? FPG_KEY_OPEN
                                                               : FPG_KEY_LOCKOUT;  // [R6] [R7]
                FPG_KEY_OPEN:
                    key_reg <= FPG_KEY_LOCKOUT;                              // [R7]
                FPG_KEY_LOCKOUT:
                    key_reg <= FPG_KEY_LOCKOUT;
            endcase
        end
        else if (sw_flash && !sw_err && key_reg != FPG_KEY_OPEN)
            key_reg <= FPG_KEY_LOCKOUT;                                      // [R8]
    end

    a_lockout_sticky: assert property (key_reg == FPG_KEY_LOCKOUT |=>
                                       key_reg == FPG_KEY_LOCKOUT)          // [R7]
        else $error("lockout left without reset");
    a_wrong_first: assert property (i_key_wr && !fl.done && key_reg == FPG_KEY_LOCKED
                                    && i_key_data != `FPG_KEY_FIRST |=>
                                    key_reg == FPG_KEY_LOCKOUT)             // [R7]
        else $error("wrong first key did not lock out");
    a_pair_opens: assert property (i_key_wr && i_key_data == `FPG_KEY_FIRST
                                   && key_reg == FPG_KEY_LOCKED && !fl.done
                                   ##[1:20] i_key_wr && i_key_data == `FPG_KEY_SECOND
                                   && key_reg == FPG_KEY_HALF && !fl.done |=>
                                   key_reg == FPG_KEY_OPEN)                 // [R6]
        else $error("key pair did not open the checker");
    a_early_store: assert property (sw_flash && !sw_err && !i_key_wr && !fl.done
                                    && key_reg != FPG_KEY_OPEN |=>
                                    key_reg == FPG_KEY_LOCKOUT)             // [R8]
        else $error("store before key pair did not lock out");
    a_key_relock: assert property (fl.done && !op_dbg_reg |=>
                                   key_reg inside {FPG_KEY_LOCKED, FPG_KEY_LOCKOUT})  // [R9]
        else $error("key checker still open after operation");

    // =========================================================
    // Operation launch
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            start_reg  <= 1'b0;
            erase_reg  <= 1'b0;
            addr_reg   <= '0;
            wdata_reg  <= '0;
            op_dbg_reg <= 1'b0;
        end
        else
        begin
            start_reg <= sw_go || dbg_go;                                    // [R1]
            if (sw_go)
            begin
                erase_reg  <= een_reg;                                       // [R13] [R14]
                addr_reg   <= i_store_addr;
                wdata_reg  <= i_store_data;
                op_dbg_reg <= 1'b0;
            end
            else if (dbg_go)
            begin
                erase_reg  <= i_dbg_erase;
                addr_reg   <= i_dbg_addr;
                wdata_reg  <= i_dbg_data;
                op_dbg_reg <= 1'b1;
            end
        end
    end

    assign fl.start = start_reg;
    assign fl.erase = erase_reg;
    assign fl.addr  = addr_reg;
    assign fl.wdata = wdata_reg;

    a_erase_mode: assert property (sw_go && een_reg |=> fl.start && fl.erase)  // [R13]
        else $error("store with both enables did not erase");
    a_no_reserved: assert property (fl.start |-> !in_reserved(fl.addr))     // [R18]
        else $error("operation launched into reserved area");

    // =========================================================
    // Processor stall
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            stall_reg <= 1'b1;
        else if (sw_go || dbg_go)
            stall_reg <= 1'b1;                                               // [R4]
        else if (fl.done || (init_reg == 2'd1))
            stall_reg <= 1'b0;                                               // [R3]
    end

    a_stall_op: assert property (sw_go |=> stall_reg [*2])                   // [R4]
        else $error("core not stalled during flash operation");
    a_stall_busy: assert property (fl.busy |-> stall_reg)                    // [R4]
        else $error("engine busy while core runs");

    // =========================================================
    // Data RAM routing
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_xram_wr   <= 1'b0;
            o_xram_rd   <= 1'b0;
            o_xram_addr <= '0;
            o_xram_data <= '0;
        end
        else
        begin
            o_xram_wr <= i_store_valid && !wen_reg && !stall_reg;            // [R10]
            o_xram_rd <= i_load_valid && !stall_reg;                         // [R17]
            if (i_store_valid && !wen_reg)
            begin
                o_xram_addr <= i_store_addr;
                o_xram_data <= i_store_data;
            end
            else if (i_load_valid)
                o_xram_addr <= i_load_addr;
        end
    end

    a_store_route: assert property (i_store_valid && !wen_reg && !stall_reg |=>
                                    o_xram_wr && o_xram_addr == $past(i_store_addr))  // [R10]
        else $error("store with write enable clear missed data RAM");
    a_load_route: assert property (i_load_valid && !stall_reg && wen_reg |=> o_xram_rd)  // [R17]
        else $error("load diverted from data RAM");

    // =========================================================
    // Code read path
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            code_pend_reg <= 1'b0;
            code_err_reg  <= 1'b0;
            o_code_valid  <= 1'b0;
            o_code_data   <= '0;
        end
        else
        begin
            code_pend_reg <= i_code_rd && !stall_reg;
            code_err_reg  <= code_err;
            o_code_valid  <= code_pend_reg;                                  // [R17]
            if (code_pend_reg)
                o_code_data <= code_err_reg ? 8'h00 : fl.rd_data;
        end
    end

    // =========================================================
    // Debug answers and flash error reset
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_dbg_ack           <= 1'b0;
            o_dbg_ignored       <= 1'b0;
            o_flash_error_reset <= 1'b0;
        end
        else
        begin
            o_dbg_ack           <= fl.done && op_dbg_reg;
            o_dbg_ignored       <= i_dbg_req && !dbg_go;                     // [R23]
            o_flash_error_reset <= sw_err || code_err;                       // [R22]
        end
    end

    a_error_cause: assert property (sw_err |=> o_flash_error_reset)          // [R22]
        else $error("prohibited store raised no flash error");
    a_dbg_quiet: assert property (i_dbg_req && !i_store_valid && !i_code_rd |=>
                                  !o_flash_error_reset)                     // [R23]
        else $error("debug request caused a flash error");

    // =========================================================
    // Status outputs
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_store_write_enable <= 1'b0;
            o_store_erase_enable <= 1'b0;
            o_key_state          <= FPG_KEY_LOCKED;
            o_lock_byte          <= `FPG_ERASED_BYTE;
            o_stall              <= 1'b1;
        end
        else
        begin
            o_store_write_enable <= wen_reg;
            o_store_erase_enable <= een_reg;
            o_key_state          <= key_reg;
            o_lock_byte          <= lock_reg;
            o_stall              <= stall_reg || sw_go || dbg_go;
        end
    end

    fpg_flash_engine #(
        .DEPTH        (DEPTH),
        .WRITE_CYCLES (WRITE_CYCLES),
        .ERASE_CYCLES (ERASE_CYCLES)
    ) u_engine (
        .i_clk     (i_clk),
        .i_reset_n (i_reset_n),
        .fl        (fl.eng)
    );

endmodule

// ### hw/fpg_pkg.sv
/*
 * Types of the flash program/erase guard.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package fpg_pkg;

    typedef enum logic [1:0]
    {
        FPG_KEY_LOCKED  = 2'h0,
        FPG_KEY_HALF    = 2'h1,
        FPG_KEY_OPEN    = 2'h3,
        FPG_KEY_LOCKOUT = 2'h2
    } fpg_key_e;

    typedef enum logic [1:0]
    {
        FPG_ENG_IDLE  = 2'h0,
        FPG_ENG_WAIT  = 2'h1,
        FPG_ENG_SWEEP = 2'h3
    } fpg_eng_e;

endpackage

// ### verification/fpg_core_model.sv
/* Core model: one key pair, then one store per go request.
   Assumes the guard runs on the same clock and stalls the core. */
`timescale 1ns/100ps
module fpg_core_model
(
    input  wire logic       i_clk,
    input  wire logic       i_reset_n,
    input  wire logic       i_stall,
    input  wire logic       i_go,
    input  wire logic       i_bad,
    output logic            o_key_wr,
    output logic [7:0]      o_key_data,
    output logic            o_store_valid
);
    logic [1:0] step_reg;
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            step_reg <= 2'h0;
            o_key_wr <= 1'b0;
            o_key_data <= 8'h00;
            o_store_valid <= 1'b0;
        end
        else
        begin
            o_key_wr <= 1'b0;
            o_store_valid <= 1'b0;
            o_key_data <= ~o_key_data;
            if (i_go && step_reg == 2'h0)
                step_reg <= 2'h1;
            else if (step_reg == 2'h1)
            begin
                o_key_wr <= 1'b1;
                o_key_data <= i_bad ? 8'h5A : 8'hA5;
                step_reg <= 2'h2;
            end
            else if (step_reg == 2'h2)
            begin
                o_key_wr <= 1'b1;
                o_key_data <= 8'hF1;
                step_reg <= 2'h3;
            end
            else if (step_reg == 2'h3 && !i_stall)
            begin
                o_store_valid <= 1'b1;
                step_reg <= 2'h0;
            end
        end
    end
endmodule

// ### verification/fpg_guard_tb.sv
/* Self-checking bench of the flash guard with a core model.
   Assumes short write and erase counts. */
`timescale 1ns/100ps
module fpg_guard_tb;
    logic i_clk = 0, i_reset_n = 0, i_ctrl_wr = 0, i_ctrl_write_en = 0, i_ctrl_erase_en = 0;
    logic go = 0, bad = 0, ts = 0, i_load_valid = 0, i_code_rd = 0, i_dbg_req = 0, h;
    logic [12:0] i_store_addr = 0, i_load_addr = 0, i_code_addr = 0, i_dbg_addr = 0, a, xa;
    logic [7:0] i_store_data = 0, kd, d, cd, o_code_data, xd;
    logic kw, ms, o_stall, o_store_write_enable, o_store_erase_enable, o_xram_wr, o_xram_rd;
    logic o_code_valid, o_dbg_ignored, o_flash_error_reset, ak, sa = 0;
    logic [1:0] o_key_state;
    logic [31:0] x = 32'd35959;
    int bad_count = 0, checked = 0, cyc = 0;
    fpg_guard #(.WRITE_CYCLES(8), .ERASE_CYCLES(16)) u_dut (.i_clk, .i_reset_n, .i_ctrl_wr,
        .i_ctrl_write_en, .i_ctrl_erase_en, .i_key_wr(kw), .i_key_data(kd),
        .i_store_valid(ts | ms), .i_store_addr, .i_store_data, .i_load_valid, .i_load_addr,
        .i_code_rd, .i_code_addr, .i_exec_addr(13'h0000), .i_dbg_req, .i_dbg_erase(1'b0),
        .i_dbg_addr, .i_dbg_data(8'h00), .o_stall, .o_store_write_enable,
        .o_store_erase_enable, .o_key_state, .o_xram_wr, .o_xram_rd, .o_xram_addr(xa),
        .o_xram_data(xd), .o_code_valid, .o_code_data, .o_dbg_ack(ak), .o_dbg_ignored,
        .o_flash_error_reset, .o_lock_byte(d));
    fpg_core_model u_core (.i_clk, .i_reset_n, .i_stall(o_stall), .i_go(go), .i_bad(bad),
        .o_key_wr(kw), .o_key_data(kd), .o_store_valid(ms));
    initial forever #2.5 i_clk = ~i_clk;
    always @(posedge i_clk) if (ak === 1'b1) sa <= 1'b1;
    function automatic logic [31:0] nx(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        return v ^ (v << 5);
    endfunction
    task chk(input logic [7:0] s, input logic [7:0] e);
        checked++;
        if (s !== e)
        begin
            bad_count++;
            $display("MISMATCH at %0t: saw %h, expected %h", $time, s, e);
        end
    endtask
    task conclude();
        $display("compares %0d, mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    always @(posedge i_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            bad_count++;
            conclude();
        end
    end
    task waitfor(input logic v);
        for (int n = 0; n < 2000 && o_stall !== v; n++)
            @(posedge i_clk);
    endtask
    task rst();
        i_reset_n <= 1'b0;
        repeat (4) @(posedge i_clk);
        i_reset_n <= 1'b1;
        waitfor(0);
    endtask
    task ctl(input logic w, input logic e);
        @(posedge i_clk);
        {i_ctrl_wr, i_ctrl_write_en, i_ctrl_erase_en} <= {1'b1, w, e};
        @(posedge i_clk);
        i_ctrl_wr <= 1'b0;
        repeat (2) @(posedge i_clk);
    endtask
    task op(input logic b, input logic [12:0] ad, input logic [7:0] dt, input logic s);
        @(posedge i_clk);
        {i_store_addr, i_store_data, bad, go} <= {ad, dt, b, 1'b1};
        @(posedge i_clk);
        go <= 1'b0;
        waitfor(s);
        waitfor(0);
        repeat (4) @(posedge i_clk);
    endtask
    task req(input int k, input logic [12:0] ad);
        @(posedge i_clk);
        {i_store_addr, i_load_addr, i_code_addr, i_dbg_addr, i_store_data} <= {{4{ad}}, ad[12:5]};
        {ts, i_load_valid, i_code_rd, i_dbg_req} <= 4'b1000 >> k;
        @(posedge i_clk);
        {ts, i_load_valid, i_code_rd, i_dbg_req} <= 4'b0000;
        h = 0;
        for (int n = 0; n < 6 && !h; n++)
        begin
            @(posedge i_clk);
            h = k == 2 ? o_code_valid : |{o_xram_wr, o_xram_rd, o_flash_error_reset, o_dbg_ignored};
        end
        cd = o_code_data;
    endtask
    initial
    begin
        rst();
        chk(d, 8'hFF);
        x = nx(x);
        a = {4'h1 + {1'b0, x[11:9]}, x[8:0]};
        req(0, a); chk(o_xram_wr, 1); chk(xa[7:0], a[7:0]); chk(xd, a[12:5]);
        req(1, a); chk(o_xram_rd, 1); chk(xa[12:5], a[12:5]);
        ctl(1, 0);
        op(0, a, x[31:24], 1); chk(o_stall, 0);
        chk(o_key_state, 0);
        chk(o_store_write_enable, 1);
        req(2, a); chk(cd, x[31:24]);
        op(0, a, 8'h0F, 1);
        req(2, a); chk(cd, x[31:24] & 8'h0F);
        ctl(1, 1);
        op(0, a ^ 13'h00A5, 8'h00, 1);
        req(2, a); chk(cd, 8'hFF);
        $display("program and erase test done");
        ctl(1, 0);
        req(0, a); chk(o_key_state, fpg_pkg::FPG_KEY_LOCKOUT);
        rst(); chk({o_key_state, o_store_write_enable, o_store_erase_enable}, 0);
        ctl(1, 0);
        op(1, a, 8'h00, 0); chk(o_key_state, fpg_pkg::FPG_KEY_LOCKOUT);
        rst(); ctl(1, 0);
        req(0, 13'h1E00); chk(o_flash_error_reset, 1);
        req(3, 13'h1E00); chk({o_dbg_ignored, o_flash_error_reset}, 2);
        req(3, a); waitfor(0); chk(sa, 1);
        ctl(0, 0); req(0, a); chk(o_xram_wr, 1);
        $display("lock and protection test done");
        conclude();
    end
endmodule
